// file: core/asx_alu.sv
// combinational alu for the byte instructions
`default_nettype none
module asx_alu
(
   input wire asx_pkg::asx_op_type op,
   input wire logic [7:0] acc,
   input wire logic [7:0] lit,
   input wire logic [7:0] fdata,
   output asx_pkg::asx_res_type res
);
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] opb;
   // literal or file operand
   assign opb = (op == asx_pkg::ASX_OP_ADD_LIT || op == asx_pkg::ASX_OP_AND_LIT) ? lit : fdata;
   assign sum = {1'b0, acc} + {1'b0, opb};
   assign nib = {1'b0, acc[3:0]} + {1'b0, opb[3:0]};
   // result select
   always_comb
   begin
      res = '0;
      unique case (op)
         asx_pkg::ASX_OP_AND_LIT, asx_pkg::ASX_OP_AND_FILE:
         begin
            res.value = acc & opb;
         end
         asx_pkg::ASX_OP_ADD_LIT, asx_pkg::ASX_OP_ADD_FILE:
         begin
            res.value = sum[7:0];
            res.c = sum[8];
            res.hc = nib[4];
         end
         asx_pkg::ASX_OP_ASR_FILE:
         begin
            res.value = {fdata[7], fdata[7:1]};
            res.c = fdata[0];
         end
         default:
         begin
            res.value = acc;
         end
      endcase
      res.z = (res.value == 8'h00);
   end
endmodule // asx_alu
`default_nettype wire

// file: core/asx_pkg.sv
// package of constants and types for the add and shift execute datapath
// Behaviour
// - pointer add sign-extends literal, flags untouched
// - operand bit selects target pointer pair
// - pointer sum wraps modulo sixteen bits
// - literal AND into accumulator, zero only
// - literal add into accumulator, three flags
// - accumulator AND file register, zero only
// - destination bit picks accumulator or file
// - accumulator add file register, three flags
// - shift right keeping sign bit
// - old bit0 to carry, zero updated
`default_nettype none
package asx_pkg;
   // apb register offsets
   localparam logic [11:0] ASX_OFF_CTRL = 12'h000;
   localparam logic [11:0] ASX_OFF_OPER = 12'h004;
   localparam logic [11:0] ASX_OFF_ACC = 12'h008;
   localparam logic [11:0] ASX_OFF_STAT = 12'h00C;
   localparam logic [11:0] ASX_OFF_PTR0 = 12'h010;
   localparam logic [11:0] ASX_OFF_PTR1 = 12'h014;
   localparam logic [11:0] ASX_OFF_FILE = 12'h018;
   // field positions
   localparam int ASX_STAT_C = 0;
   localparam int ASX_STAT_HC = 1;
   localparam int ASX_STAT_Z = 2;
   localparam int ASX_OPER_DEST = 15;
   localparam int ASX_OPER_SEL = 6;
   // reset values and file register depth
   localparam logic [7:0] ASX_ACC_RST = 8'h00;
   localparam logic [15:0] ASX_PTR_RST = 16'h0000;
   localparam logic [2:0] ASX_STAT_RST = 3'h0;
   localparam int ASX_FILE_DEPTH = 128;
   // operation codes written to control
   typedef enum logic [2:0]
   {
      ASX_OP_PTR_ADD = 3'h0,
      ASX_OP_AND_LIT = 3'h1,
      ASX_OP_ADD_LIT = 3'h2,
      ASX_OP_AND_FILE = 3'h3,
      ASX_OP_ADD_FILE = 3'h4,
      ASX_OP_ASR_FILE = 3'h5
   } asx_op_type;
   // one instruction as issued to the execute unit
   typedef struct packed
   {
      asx_op_type op;
      logic dest;
      logic [7:0] lit;
      logic [6:0] addr;
   } asx_instr_type;
   // alu result with flags
   typedef struct packed
   {
      logic [7:0] value;
      logic c;
      logic hc;
      logic z;
   } asx_res_type;
endpackage
`default_nettype wire

// file: core/asx_ptr_add.sv
// indirect pointer plus signed six-bit literal
`default_nettype none
module asx_ptr_add
(
   input wire logic [15:0] ptr,
   input wire logic [5:0] k,
   output logic [15:0] sum
);
   // sign extend and wrap
   assign sum = ptr + {{10{k[5]}}, k};
endmodule // asx_ptr_add
`default_nettype wire

// file: core/asx_top.sv
// apb-controlled execute datapath with file registers and pointers
`default_nettype none
module asx_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   logic [7:0] acc_q;
   logic [15:0] ptr_q [2];
   logic [2:0] stat_q;
   logic [15:0] oper_q;
   logic [7:0] file_mem [asx_pkg::ASX_FILE_DEPTH];
   logic [6:0] file_idx_q;
   logic [31:0] rdata_d;
   logic [31:0] prdata_q;
   logic rd_setup;
   logic file_op;
   logic wr_acc;
   logic acc_en;
   logic hit;
   logic go;
   logic sel;
   logic [15:0] psum;
   logic [7:0] fdata;
   asx_pkg::asx_instr_type ins;
   asx_pkg::asx_res_type res;
   asx_pkg::asx_op_type op;
   // apb decode
   assign acc_en = psel & penable;
   assign wr_acc = acc_en & pwrite;
   assign go = wr_acc & (paddr == asx_pkg::ASX_OFF_CTRL);
   assign rd_setup = psel & ~penable & ~pwrite;
   assign op = asx_pkg::asx_op_type'(pwdata[2:0]);
   assign ins.op = op;
   // only the file instructions may store into the file registers
   assign file_op = (op == asx_pkg::ASX_OP_AND_FILE) | (op == asx_pkg::ASX_OP_ADD_FILE)
      | (op == asx_pkg::ASX_OP_ASR_FILE);
   assign ins.dest = oper_q[asx_pkg::ASX_OPER_DEST];
   assign ins.lit = oper_q[7:0];
   assign ins.addr = oper_q[14:8];
   assign sel = oper_q[asx_pkg::ASX_OPER_SEL];
   assign fdata = file_mem[ins.addr];
   assign hit = (paddr == asx_pkg::ASX_OFF_CTRL) | (paddr == asx_pkg::ASX_OFF_OPER)
      | (paddr == asx_pkg::ASX_OFF_ACC) | (paddr == asx_pkg::ASX_OFF_STAT)
      | (paddr == asx_pkg::ASX_OFF_PTR0) | (paddr == asx_pkg::ASX_OFF_PTR1)
      | (paddr == asx_pkg::ASX_OFF_FILE);
   assign pready = 1'b1;
   assign pslverr = acc_en & ~hit;
   asx_alu u_alu
   (
      .op(ins.op),
      .acc(acc_q),
      .lit(ins.lit),
      .fdata(fdata),
      .res(res)
   );
   asx_ptr_add u_ptr
   (
      .ptr(ptr_q[sel]),
      .k(oper_q[5:0]),
      .sum(psum)
   );
   // read mux
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      unique case (paddr)
         asx_pkg::ASX_OFF_OPER: rdata_d = {16'h0000, oper_q};
         asx_pkg::ASX_OFF_ACC: rdata_d = {24'h000000, acc_q};
         asx_pkg::ASX_OFF_STAT: rdata_d = {29'h0, stat_q};
         asx_pkg::ASX_OFF_PTR0: rdata_d = {16'h0000, ptr_q[0]};
         asx_pkg::ASX_OFF_PTR1: rdata_d = {16'h0000, ptr_q[1]};
         asx_pkg::ASX_OFF_FILE: rdata_d = {17'h0, file_idx_q, file_mem[file_idx_q]};
         default: rdata_d = 32'h0000_0000;
      endcase
   end
   assign prdata = prdata_q;
   // read data taken in the setup cycle, stands through the access phase only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         prdata_q <= rd_setup ? rdata_d : 32'h0000_0000;
      end
   end
   // operand register, pointers, accumulator, status
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         oper_q <= 16'h0000;
         acc_q <= asx_pkg::ASX_ACC_RST;
         stat_q <= asx_pkg::ASX_STAT_RST;
         ptr_q[0] <= asx_pkg::ASX_PTR_RST;
         ptr_q[1] <= asx_pkg::ASX_PTR_RST;
         file_idx_q <= 7'h00;
      end
      else if (go)
      begin
         if (op == asx_pkg::ASX_OP_PTR_ADD)
         begin
            ptr_q[sel] <= psum;
         end
         else
         begin
            if (op == asx_pkg::ASX_OP_AND_LIT || op == asx_pkg::ASX_OP_ADD_LIT || !ins.dest)
            begin
               acc_q <= res.value;
            end
            stat_q[asx_pkg::ASX_STAT_Z] <= res.z;
            if (op == asx_pkg::ASX_OP_ADD_LIT || op == asx_pkg::ASX_OP_ADD_FILE)
            begin
               stat_q[asx_pkg::ASX_STAT_C] <= res.c;
               stat_q[asx_pkg::ASX_STAT_HC] <= res.hc;
            end
            if (op == asx_pkg::ASX_OP_ASR_FILE)
            begin
               stat_q[asx_pkg::ASX_STAT_C] <= res.c;
            end
         end
      end
      else if (wr_acc)
      begin
         unique case (paddr)
            asx_pkg::ASX_OFF_OPER: oper_q <= pwdata[15:0];
            asx_pkg::ASX_OFF_ACC: acc_q <= pwdata[7:0];
            asx_pkg::ASX_OFF_STAT: stat_q <= pwdata[2:0];
            asx_pkg::ASX_OFF_PTR0: ptr_q[0] <= pwdata[15:0];
            asx_pkg::ASX_OFF_PTR1: ptr_q[1] <= pwdata[15:0];
            asx_pkg::ASX_OFF_FILE: file_idx_q <= pwdata[14:8];
            default: oper_q <= oper_q;
         endcase
      end
   end
   // file registers, no reset
   always_ff @(posedge pclk)
   begin
      if (go && ins.dest && file_op)
      begin
         file_mem[ins.addr] <= res.value;
      end
      else if (wr_acc && paddr == asx_pkg::ASX_OFF_FILE)
      begin
         file_mem[pwdata[14:8]] <= pwdata[7:0];
      end
   end
endmodule // asx_top
`default_nettype wire

// file: test/asx_apb_seq.sv
// partner model: apb handshake sequencer standing in for the core decoder
`default_nettype none
module asx_apb_seq
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go,
   input wire logic pready,
   output logic psel,
   output logic penable
);
   // setup cycle, then access until ready, then release
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) {psel, penable} <= 2'b00;
      else if (psel && penable && pready) {psel, penable} <= 2'b00;
      else if (psel) penable <= 1'b1;
      else if (go) psel <= 1'b1;
endmodule // asx_apb_seq
`default_nettype wire

// file: test/asx_port_assertions.sv
// port checker for the execute datapath
`default_nettype none
module asx_port_checker
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // access phase and read decode
   wire acc = psel && penable;
   wire rd = acc && !pwrite;
   sequence ptr_rd_s;
      rd && (paddr == 12'h010 || paddr == 12'h014);
   endsequence
   a_ready_now: assert property (acc |-> pready) else $error("no ready");
   a_err_unmapped: assert property (acc && paddr > 12'h018 |-> pslverr) else $error("no err");
   a_err_quiet: assert property (!acc |-> !pslverr) else $error("stray err");
   a_rd_quiet: assert property (!acc |-> prdata == 32'h0) else $error("stray data");
   a_ctrl_zero: assert property (rd && paddr == 12'h000 |-> prdata == 32'h0) else $error("ctrl");
   a_ptr_width: assert property (ptr_rd_s |-> prdata[31:16] == 16'h0)
      else $error("ptr width");
   a_acc_width: assert property (rd && paddr == 12'h008 |-> prdata[31:8] == 24'h0)
      else $error("acc width");
   a_stat_width: assert property (rd && paddr == 12'h00C |-> prdata[31:3] == 29'h0)
      else $error("stat width");
endmodule // asx_port_checker
bind asx_top asx_port_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr));
`default_nettype wire

// file: test/tb_add_and_shift_execute_datapath.sv
// self-checking bench for the execute datapath
`default_nettype none
module tb_add_and_shift_execute_datapath;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic go = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic psel, penable, pready, pslverr;
   logic [31:0] prdata;
   int err_total = 0;
   int num_checks = 0;
   asx_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   asx_apb_seq u_mst (.pclk(pclk), .presetn(presetn), .go(go), .pready(pready),
      .psel(psel), .penable(penable));
   // 125 MHz clock
   always #4 pclk = ~pclk;
   // one apb transfer, held until ready is sampled
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge pclk);
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      do @(posedge pclk); while (!(psel && penable && pready));
      r = prdata;
      e = pslverr;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x)
      begin
         err_total++;
         $display("BAD %0t got %h want %h", $time, g, x);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      xfer(1'b1, a, d, r, e);
   endtask
   task automatic chk(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      xfer(1'b0, a, 32'h0, r, e);
      cmp(r, x);
      cmp({31'h0, e}, 32'h0);
   endtask
   task automatic op(input logic [31:0] oper, input logic [31:0] code);
      wr(12'h004, oper);
      wr(12'h000, code);
   endtask
   // pointer add: negative literal, wrap, pair select
   task automatic t_ptr;
      wr(12'h010, 32'h5);
      wr(12'h00C, 32'h7);
      op(32'h20, 32'h0);
      chk(12'h010, 32'hFFE5);
      chk(12'h00C, 32'h7);
      wr(12'h014, 32'hFFFF);
      op(32'h41, 32'h0);
      chk(12'h014, 32'h0);
      chk(12'h010, 32'hFFE5);
   endtask
   // literal and/add into accumulator
   task automatic t_lit;
      wr(12'h008, 32'hF0);
      wr(12'h00C, 32'h3);
      op(32'h0F, 32'h1);
      chk(12'h008, 32'h0);
      chk(12'h00C, 32'h7);
      wr(12'h008, 32'h8F);
      op(32'h71, 32'h2);
      chk(12'h00C, 32'h7);
      wr(12'h008, 32'h1);
      op(32'h2, 32'h2);
      chk(12'h008, 32'h3);
      chk(12'h00C, 32'h0);
   endtask
   // file and/add with both destinations
   task automatic t_file;
      wr(12'h018, 32'h7F3C);
      wr(12'h008, 32'hAA);
      wr(12'h00C, 32'h3);
      op(32'hFF00, 32'h3);
      chk(12'h018, 32'h7F28);
      chk(12'h008, 32'hAA);
      chk(12'h00C, 32'h3);
      wr(12'h018, 32'h0088);
      wr(12'h008, 32'h88);
      op(32'h0000, 32'h4);
      chk(12'h008, 32'h10);
      chk(12'h00C, 32'h3);
      chk(12'h018, 32'h0088);
   endtask
   // arithmetic shift right, sign kept, bit0 to carry
   task automatic t_asr;
      wr(12'h018, 32'h0581);
      wr(12'h00C, 32'h2);
      op(32'h8500, 32'h5);
      chk(12'h018, 32'h05C0);
      chk(12'h00C, 32'h3);
      wr(12'h018, 32'h0501);
      op(32'h0500, 32'h5);
      chk(12'h008, 32'h0);
      chk(12'h00C, 32'h7);
   endtask
   // undefined codes leave data alone, zero follows accumulator
   task automatic t_inv;
      wr(12'h008, 32'h5A);
      wr(12'h00C, 32'h3);
      op(32'h8500, 32'h6);
      chk(12'h008, 32'h5A);
      chk(12'h00C, 32'h3);
      chk(12'h018, 32'h0501);
      wr(12'h008, 32'h0);
      op(32'h8500, 32'h7);
      chk(12'h00C, 32'h7);
      chk(12'h018, 32'h0501);
   endtask
   // mid-run reset clears registers, file contents survive
   task automatic t_rst;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      chk(12'h000, 32'h0);
      chk(12'h004, 32'h0);
      chk(12'h008, 32'h0);
      chk(12'h00C, 32'h0);
      chk(12'h010, 32'h0);
      chk(12'h014, 32'h0);
      chk(12'h018, 32'h0088);
   endtask
   // unmapped address refused
   task automatic t_bad;
      logic [31:0] r;
      logic e;
      xfer(1'b0, 12'h100, 32'h0, r, e);
      cmp(r, 32'h0);
      cmp({31'h0, e}, 32'h1);
   endtask
   task automatic end_of_test;
      if (err_total == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // main sequence
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_ptr;
      t_lit;
      t_file;
      t_asr;
      t_inv;
      t_bad;
      t_rst;
      end_of_test;
   end
   // watchdog
   initial
   begin
      repeat (3000) @(posedge pclk);
      err_total++;
      end_of_test;
   end
endmodule // tb_add_and_shift_execute_datapath
`default_nettype wire
